// [ccu_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ccu_regs.svh"
module ccu_top #(
    parameter int TB_WIDTH = 16
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic [2:0]    addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output logic      [7:0]    rd_data,
    input  wire ccu_pkg::ccu_count_t first_timebase_count,
    input  wire ccu_pkg::ccu_count_t third_timebase_count,
    output logic               first_timebase_reset,
    output logic               third_timebase_reset,
    input  wire logic          adc_enabled,
    output logic               adc_start,
    input  wire logic          pwm_level,
    input  wire logic          capture_compare_pin_in,
    output logic      [3:0]    pin_out,
    output logic      [3:0]    pin_oe,
    output logic               unit_event_flag,
    output logic               unit_event_enable
);
    import ccu_pkg::*;

    generate
        if (TB_WIDTH != 16) begin : g_bad_width
            $error("ccu_top supports only a 16-bit timebase");
        end
    endgenerate

    logic [3:0]  mode;
    logic [1:0]  duty_lsb;
    logic [1:0]  pwm_output_mode;
    ccu_count_t  capture_compare_value;
    logic        third_sel;
    logic [3:0]  port_c_direction;
    logic [3:0]  port_c_a;
    logic [3:0]  presc;
    logic        cmp_latch;
    logic        match_q;

    logic [3:0]  next_mode;
    logic [1:0]  next_duty_lsb;
    logic [1:0]  next_pwm_output_mode;
    ccu_count_t  next_value;
    logic        next_flag;
    logic        next_enable;
    logic        next_third_sel;
    logic [3:0]  next_dir;
    logic [3:0]  next_port;
    logic [3:0]  next_presc;
    logic        next_latch;
    logic [7:0]  next_rd_data;
    logic        next_t1_reset;
    logic        next_t3_reset;
    logic        next_adc_start;
    logic [3:0]  next_pin_out;
    logic [3:0]  pwm_act;
    logic [3:0]  pwm_val;
    logic [3:0]  pwm_pol;

    ccu_class_e  mode_class;
    ccu_count_t  timebase;
    logic        pin_rise;
    logic        pin_fall;
    logic        match;
    logic        cap_event;
    logic        cmp_event;
    logic        presc_hit;
    logic        cmp_drives;

    // Pin is sampled from the wire, so driven levels are seen too
    ccu_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (capture_compare_pin_in),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    always_comb begin
        case (mode)
            `CCU_MODE_OFF:                  mode_class = CCU_CL_OFF;
            4'h4, 4'h5, 4'h6, 4'h7:         mode_class = CCU_CL_CAPT;
            4'h2, 4'h8, 4'h9, 4'ha, 4'hb:   mode_class = CCU_CL_CMP;
            4'hc, 4'hd, 4'he, 4'hf:         mode_class = CCU_CL_PWM;
            default:                        mode_class = CCU_CL_RSVD;
        endcase
    end

    // Event detection
    always_comb begin
        timebase   = third_sel ? third_timebase_count : first_timebase_count;
        match      = (mode_class == CCU_CL_CMP) && (capture_compare_value == timebase);
        // Only the first cycle of a match acts, a stalled timer would retoggle
        cmp_event  = match & ~match_q;
        presc_hit  = 1'b0;
        cap_event  = 1'b0;
        case (mode)
            `CCU_MODE_CAP_FALL: cap_event = pin_fall;
            `CCU_MODE_CAP_RISE: cap_event = pin_rise;
            `CCU_MODE_CAP_4: begin
                presc_hit = presc >= `CCU_PRESC_4_LAST;
                cap_event = pin_rise & presc_hit;
            end
            `CCU_MODE_CAP_16: begin
                presc_hit = presc >= `CCU_PRESC_16_LAST;
                cap_event = pin_rise & presc_hit;
            end
            default: cap_event = 1'b0;
        endcase
        cmp_drives = (mode == `CCU_MODE_TOGGLE) || (mode == `CCU_MODE_CMP_SET)
                     || (mode == `CCU_MODE_CMP_CLR);
    end

    // Register file and core state
    always_comb begin
        next_mode            = mode;
        next_duty_lsb        = duty_lsb;
        next_pwm_output_mode = pwm_output_mode;
        next_value           = capture_compare_value;
        next_flag            = unit_event_flag;
        next_enable          = unit_event_enable;
        next_third_sel       = third_sel;
        next_dir             = port_c_direction;
        next_port            = port_c_a;
        next_presc           = presc;
        next_latch           = cmp_latch;
        next_rd_data         = 8'h00;
        next_t1_reset        = 1'b0;
        next_t3_reset        = 1'b0;
        next_adc_start       = 1'b0;
        if (wr_en) begin
            case (addr)
                `CCU_ADDR_CTRL: begin
                    next_mode            = wr_data[`CCU_CTRL_MODE_LSB +: 4];
                    next_duty_lsb        = wr_data[`CCU_CTRL_DUTY_LSB +: 2];
                    next_pwm_output_mode = wr_data[`CCU_CTRL_POM_LSB +: 2];
                end
                `CCU_ADDR_VAL_LO: next_value[7:0]  = wr_data;
                `CCU_ADDR_VAL_HI: next_value[15:8] = wr_data;
                `CCU_ADDR_STATUS: begin
                    next_flag   = wr_data[`CCU_STAT_FLAG_BIT];
                    next_enable = wr_data[`CCU_STAT_IEN_BIT];
                end
                `CCU_ADDR_TSEL:   next_third_sel = wr_data[`CCU_TSEL_BIT];
                `CCU_ADDR_DIR:    next_dir       = wr_data[3:0];
                `CCU_ADDR_PORT:   next_port      = wr_data[3:0];
                default:          next_mode      = mode;
            endcase
        end
        if (rd_en) begin
            case (addr)
                `CCU_ADDR_CTRL:   next_rd_data = {pwm_output_mode, duty_lsb, mode};
                `CCU_ADDR_VAL_LO: next_rd_data = capture_compare_value[7:0];
                `CCU_ADDR_VAL_HI: next_rd_data = capture_compare_value[15:8];
                `CCU_ADDR_STATUS: next_rd_data = {6'h00, unit_event_enable, unit_event_flag};
                `CCU_ADDR_TSEL:   next_rd_data = {7'h00, third_sel};
                `CCU_ADDR_DIR:    next_rd_data = {4'h0, port_c_direction};
                `CCU_ADDR_PORT:   next_rd_data = {4'h0, port_c_a};
                default:          next_rd_data = 8'h00;
            endcase
        end
        // Prescaler survives switches between capture settings
        if (mode_class != CCU_CL_CAPT) begin
            next_presc = 4'h0;
        end else if (pin_rise && (mode == `CCU_MODE_CAP_4 || mode == `CCU_MODE_CAP_16)) begin
            next_presc = presc_hit ? 4'h0 : presc + 4'h1;
        end
        if (cap_event) begin
            next_value = timebase;
        end
        // Hardware set beats a same-cycle software clear
        if (cap_event || cmp_event) begin
            next_flag = 1'b1;
        end
        if (cmp_event) begin
            case (mode)
                `CCU_MODE_CMP_SET: next_latch = 1'b1;
                `CCU_MODE_CMP_CLR: next_latch = 1'b0;
                `CCU_MODE_TOGGLE:  next_latch = ~cmp_latch;
                `CCU_MODE_SPECIAL: begin
                    next_t1_reset  = ~third_sel;
                    next_t3_reset  = third_sel;
                    next_adc_start = adc_enabled;
                end
                default: next_latch = cmp_latch;
            endcase
        end
        if (mode == `CCU_MODE_OFF) begin
            next_latch = 1'b0;
        end
        if (next_mode != mode) begin
            case (next_mode)
                `CCU_MODE_CMP_SET: next_latch = 1'b0;
                `CCU_MODE_CMP_CLR: next_latch = 1'b1;
                `CCU_MODE_OFF:     next_latch = 1'b0;
                default:           next_latch = next_latch;
            endcase
        end
    end

    // Enhanced output steering
    always_comb begin
        pwm_act = 4'h0;
        pwm_val = 4'h0;
        if (mode_class == CCU_CL_PWM) begin
            case (pwm_output_mode)
                `CCU_POM_SINGLE: begin
                    pwm_act = 4'b0001;
                    pwm_val = {3'b000, pwm_level};
                end
                `CCU_POM_HALF: begin
                    pwm_act = 4'b0011;
                    pwm_val = {2'b00, ~pwm_level, pwm_level};
                end
                `CCU_POM_FWD: begin
                    pwm_act = 4'b1111;
                    pwm_val = {pwm_level, 2'b00, 1'b1};
                end
                default: begin
                    pwm_act = 4'b1111;
                    pwm_val = {1'b0, 1'b1, pwm_level, 1'b0};
                end
            endcase
        end
        pwm_pol = {mode[0], mode[1], mode[0], mode[1]};
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            if (gi == 0) begin : g_main
                // Software-interrupt and special modes fall back to the port latch
                assign next_pin_out[gi] = pwm_act[gi] ? (pwm_val[gi] ^ pwm_pol[gi])
                                        : cmp_drives  ? cmp_latch
                                        : port_c_a[gi];
            end else begin : g_aux
                assign next_pin_out[gi] = pwm_act[gi] ? (pwm_val[gi] ^ pwm_pol[gi])
                                        : port_c_a[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {pwm_output_mode, duty_lsb, mode} <= `CCU_RST_CTRL;
            capture_compare_value <= 16'h0000;
            unit_event_flag       <= 1'b0;
            unit_event_enable     <= 1'b0;
            third_sel             <= 1'b0;
            port_c_direction      <= `CCU_RST_DIR;
            port_c_a              <= `CCU_RST_PORT;
            presc                 <= 4'h0;
            cmp_latch             <= 1'b0;
            match_q               <= 1'b0;
            rd_data               <= 8'h00;
            first_timebase_reset  <= 1'b0;
            third_timebase_reset  <= 1'b0;
            adc_start             <= 1'b0;
            pin_out               <= 4'h0;
            pin_oe                <= 4'h0;
        end else begin
            mode                  <= next_mode;
            duty_lsb              <= next_duty_lsb;
            pwm_output_mode       <= next_pwm_output_mode;
            capture_compare_value <= next_value;
            unit_event_flag       <= next_flag;
            unit_event_enable     <= next_enable;
            third_sel             <= next_third_sel;
            port_c_direction      <= next_dir;
            port_c_a              <= next_port;
            presc                 <= next_presc;
            cmp_latch             <= next_latch;
            match_q               <= match;
            rd_data               <= next_rd_data;
            first_timebase_reset  <= next_t1_reset;
            third_timebase_reset  <= next_t3_reset;
            adc_start             <= next_adc_start;
            pin_out               <= next_pin_out;
            pin_oe                <= ~port_c_direction;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_capture_loads: assert property (cap_event |=> capture_compare_value == $past(timebase))
        else $error("capture did not load timebase");
    a_capture_flag: assert property (cap_event |=> unit_event_flag)
        else $error("capture did not set flag");
    a_fall_select: assert property ((mode == `CCU_MODE_CAP_FALL) && pin_fall |-> cap_event)
        else $error("falling edge missed");
    a_sixteenth_edge: assert property ((mode == `CCU_MODE_CAP_16) && pin_rise
                                       && (presc != `CCU_PRESC_16_LAST) |-> !cap_event)
        else $error("capture before sixteenth edge");
    a_presc_cleared: assert property ((mode_class != CCU_CL_CAPT) |=> presc == 4'h0)
        else $error("prescaler not cleared");
    a_set_on_match: assert property (cmp_event && (mode == `CCU_MODE_CMP_SET)
                                     && !wr_en |=> cmp_latch)
        else $error("latch not set on match");
    a_toggle_match: assert property (cmp_event && (mode == `CCU_MODE_TOGGLE) && !wr_en
                                     |=> cmp_latch != $past(cmp_latch))
        else $error("latch not toggled");
    a_swint_pin: assert property ((mode == `CCU_MODE_SWINT) ##1 (mode == `CCU_MODE_SWINT) && !pwm_act[0]
                                  |-> pin_out[0] == $past(port_c_a[0]))
        else $error("pin disturbed in software interrupt mode");
    a_special_reset: assert property (cmp_event && (mode == `CCU_MODE_SPECIAL) && !third_sel
                                      |=> first_timebase_reset && !third_timebase_reset)
        else $error("special event did not reset first timebase");
    a_adc_gated: assert property (adc_start |-> $past(adc_enabled) && $past(cmp_event))
        else $error("conversion started while converter off");
    a_off_latch: assert property ((mode == `CCU_MODE_OFF) && (next_mode == `CCU_MODE_OFF)
                                  |=> !cmp_latch)
        else $error("compare latch not forced low");
    a_match_flag: assert property (cmp_event |=> unit_event_flag)
        else $error("match did not set flag");
endmodule : ccu_top
`default_nettype wire

// [ccu_regs.svh]
// Overview of operation
// - In capture mode copy the selected 16-bit timebase into the result pair.
// - Capture on falling, rising, every fourth or every sixteenth rising edge.
// - Each capture sets the event flag; only software clears it.
// - A newer capture overwrites an unread earlier result.
// - Pin level is observed even when driven, so port writes can capture.
// - Capture/compare use first or third timebase, chosen by assignment bit.
// - Prescaler counter clears when module off or capture mode left.
// - Switching between prescaler settings keeps the prescaler count.
// - Compare mode continuously compares the value against the selected timebase.
// - On match drive high, low, toggle or leave pin; set flag.
// - Software-interrupt compare mode only sets the flag, pin untouched.
// - Special event match pulses a reset of the assigned timebase.
// - Special event also starts conversion, only if converter enabled.
// - Clearing control forces the compare latch low, port latch kept.
// - Four PWM outputs, active per output mode, mode field and direction.
// - Modes 0100 to 0111 select the four capture event kinds.
// - 1000 init low set on match, 1001 init high clear, 0010 toggles.
// - Mode 0000 turns every function off and clears the compare latch and prescaler.
`ifndef CCU_REGS_SVH
`define CCU_REGS_SVH

`define CCU_ADDR_CTRL      3'h0
`define CCU_ADDR_VAL_LO    3'h1
`define CCU_ADDR_VAL_HI    3'h2
`define CCU_ADDR_STATUS    3'h3
`define CCU_ADDR_TSEL      3'h4
`define CCU_ADDR_DIR       3'h5
`define CCU_ADDR_PORT      3'h6

`define CCU_CTRL_MODE_LSB  0
`define CCU_CTRL_DUTY_LSB  4
`define CCU_CTRL_POM_LSB   6
`define CCU_STAT_FLAG_BIT  0
`define CCU_STAT_IEN_BIT   1
`define CCU_TSEL_BIT       0

`define CCU_RST_CTRL       8'h00
`define CCU_RST_DIR        4'hf
`define CCU_RST_PORT       4'h0

`define CCU_MODE_OFF       4'h0
`define CCU_MODE_TOGGLE    4'h2
`define CCU_MODE_CAP_FALL  4'h4
`define CCU_MODE_CAP_RISE  4'h5
`define CCU_MODE_CAP_4     4'h6
`define CCU_MODE_CAP_16    4'h7
`define CCU_MODE_CMP_SET   4'h8
`define CCU_MODE_CMP_CLR   4'h9
`define CCU_MODE_SWINT     4'ha
`define CCU_MODE_SPECIAL   4'hb

`define CCU_PRESC_4_LAST   4'h3
`define CCU_PRESC_16_LAST  4'hf

`define CCU_POM_SINGLE     2'h0
`define CCU_POM_FWD        2'h1
`define CCU_POM_HALF       2'h2
`define CCU_POM_REV        2'h3

`endif

// [ccu_pkg.sv]
package ccu_pkg;
    typedef enum logic [4:0] {
        CCU_CL_OFF  = 5'b0_0001,
        CCU_CL_CAPT = 5'b0_0010,
        CCU_CL_CMP  = 5'b0_0100,
        CCU_CL_PWM  = 5'b0_1000,
        CCU_CL_RSVD = 5'b1_0000
    } ccu_class_e;
    typedef logic [15:0] ccu_count_t;
endpackage : ccu_pkg

// [ccu_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ccu_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic next_lvl;
    logic agree;

    // Level changes only once second and third stages agree
    always_comb begin
        agree    = (s2 == s3);
        next_lvl = agree ? s3 : lvl;
        rise     = agree & s3 & ~lvl;
        fall     = agree & ~s3 & lvl;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1  <= 1'b0;
            s2  <= 1'b0;
            s3  <= 1'b0;
            lvl <= 1'b0;
        end else begin
            s1  <= pin_in;
            s2  <= s1;
            s3  <= s2;
            lvl <= next_lvl;
        end
    end
endmodule : ccu_sync
`default_nettype wire

// [ccu_timer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccu_timer_model (
    input  wire logic                first_timebase_reset,
    input  wire logic                third_timebase_reset,
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                run,
    input  wire logic                load,
    input  wire ccu_pkg::ccu_count_t load_val,
    input  wire logic                pin_drive,
    input  wire logic                pin_out_a,
    input  wire logic                pin_oe_a,
    output ccu_pkg::ccu_count_t      first_timebase_count,
    output ccu_pkg::ccu_count_t      third_timebase_count,
    output logic                     pin_level
);
    import ccu_pkg::*;
    // Offset keeps the two time bases distinguishable in a capture
    localparam ccu_count_t THIRD_OFS = 16'h1000;
    // Counts on the core clock only, never as an asynchronous counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            first_timebase_count <= 16'h0000;
            third_timebase_count <= 16'h0000;
        end else if (load) begin
            first_timebase_count <= load_val;
            third_timebase_count <= load_val + THIRD_OFS;
        end else begin
            if (first_timebase_reset) begin
                first_timebase_count <= 16'h0000;
            end else if (run) begin
                first_timebase_count <= first_timebase_count + 16'h0001;
            end
            if (third_timebase_reset) begin
                third_timebase_count <= 16'h0000;
            end else if (run) begin
                third_timebase_count <= third_timebase_count + 16'h0001;
            end
        end
    end
    // Driven pin wins, so a port write is seen on the pin
    assign pin_level = pin_oe_a ? pin_out_a : pin_drive;
endmodule : ccu_timer_model
`default_nettype wire

// [capture_compare_unit_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit_tb_top;
    import ccu_pkg::*;
    logic       core_clk, rst, wr_en, rd_en, adc_enabled, adc_start, pwm_level;
    logic [2:0] addr;
    logic [7:0] wr_data, rd_data, d;
    logic       f_rst, t_rst, flag, ien, run, load, ext, pin;
    logic [3:0] pin_out, pin_oe;
    ccu_count_t f_cnt, t_cnt, load_val, v;
    int         mismatches, n_tests, i, k;
    logic [3:0] modes [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
    logic [7:0] pctl [5] = '{8'h8c, 8'h4c, 8'h4f, 8'hcd, 8'h0e};
    logic [3:0] pexp [5] = '{4'b0001, 4'b1001, 4'b0110, 4'b1100, 4'b0000};

    ccu_top uut (.core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .first_timebase_count(f_cnt),
        .third_timebase_count(t_cnt), .first_timebase_reset(f_rst),
        .third_timebase_reset(t_rst), .adc_enabled(adc_enabled), .adc_start(adc_start),
        .pwm_level(pwm_level), .capture_compare_pin_in(pin), .pin_out(pin_out),
        .pin_oe(pin_oe), .unit_event_flag(flag), .unit_event_enable(ien));
    ccu_timer_model far (.first_timebase_reset(f_rst), .third_timebase_reset(t_rst),
        .core_clk(core_clk), .rst(rst), .run(run), .load(load), .load_val(load_val),
        .pin_drive(ext), .pin_out_a(pin_out[0]), .pin_oe_a(pin_oe[0]),
        .first_timebase_count(f_cnt), .third_timebase_count(t_cnt), .pin_level(pin));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic final_report;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] dat);
        @(posedge core_clk);
        addr <= a;
        wr_data <= dat;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] dat);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        dat = rd_data;
    endtask : rd

    task automatic ld(input ccu_count_t val);
        @(posedge core_clk);
        load <= 1'b1;
        load_val <= val;
        @(posedge core_clk);
        load <= 1'b0;
    endtask : ld

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    // Edges kept several cycles apart so the synchroniser sees each one
    task automatic pulse(input int n);
        repeat (n) begin
            ext <= 1'b1;
            cyc(5);
            ext <= 1'b0;
            cyc(5);
        end
    endtask : pulse

    task automatic get16(output ccu_count_t val);
        rd(3'h1, val[7:0]);
        rd(3'h2, val[15:8]);
    endtask : get16

    initial begin
        #400000;
        mismatches++;
        final_report();
    end

    initial begin
        {rst, wr_en, rd_en, adc_enabled, pwm_level, run, load, ext} = 8'h80;
        {addr, wr_data, load_val, mismatches, n_tests} = '0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(3'h3, d); chk("status", d, 16'h0000);
        rd(3'h5, d); chk("dir", d, 16'h000f);
        rd(3'h0, d); chk("ctrl", d, 16'h0000);
        chk("pin_oe", pin_oe, 16'h0000);
        wr(3'h3, 8'h02); rd(3'h3, d); chk("enable", d, 16'h0002);
        chk("enable pin", ien, 16'h0001);
        wr(3'h7, 8'hff); rd(3'h7, d); chk("unmapped", d, 16'h0000);
        wr(3'h3, 8'h00);
        ld(16'h1234); wr(3'h0, 8'h05); pulse(1);
        get16(v); chk("capture", v, 16'h1234);
        chk("flag", flag, 16'h0001);
        rd(3'h3, d); chk("flag kept", d, 16'h0001);
        ld(16'h5678); pulse(1);
        get16(v); chk("overwrite", v, 16'h5678);
        wr(3'h4, 8'h01); wr(3'h0, 8'h04); wr(3'h3, 8'h00); ld(16'h0100);
        ext <= 1'b1; cyc(6); chk("rise ignored", flag, 16'h0000);
        ext <= 1'b0; cyc(6); chk("fall", flag, 16'h0001);
        get16(v); chk("third base", v, 16'h1100);
        wr(3'h4, 8'h00);
        for (i = 0; i < 2; i++) begin
            k = i ? 16 : 4;
            wr(3'h0, 8'h00); wr(3'h0, i ? 8'h07 : 8'h06); wr(3'h3, 8'h00);
            pulse(k - 1); chk("prescale early", flag, 16'h0000);
            pulse(1); chk("prescale hit", flag, 16'h0001);
        end
        wr(3'h0, 8'h00); wr(3'h0, 8'h06); pulse(2);
        wr(3'h0, 8'h00); wr(3'h0, 8'h06); wr(3'h3, 8'h00);
        pulse(3); chk("prescale cleared", flag, 16'h0000);
        wr(3'h0, 8'h07); pulse(5); wr(3'h0, 8'h06); wr(3'h3, 8'h00);
        pulse(1); chk("prescale kept", flag, 16'h0001);
        wr(3'h0, 8'h05); wr(3'h5, 8'h0e); wr(3'h3, 8'h00); wr(3'h6, 8'h01); cyc(6);
        chk("port capture", flag, 16'h0001);
        // Compare modes share one match value; timer restarted from zero each time
        wr(3'h1, 8'h40); wr(3'h2, 8'h00); run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(3'h0, 8'h00); wr(3'h6, {7'h00, modes[i] == 4'ha});
            rd(3'h6, d); chk("port latch", d, {15'h0000, modes[i] == 4'ha});
            wr(3'h3, 8'h00); ld(16'h0000); wr(3'h0, {4'h0, modes[i]}); cyc(2);
            chk("pin init", pin_out[0], {15'h0000, i[0]});
            for (k = 0; k < 200 && flag !== 1'b1; k++) cyc(1);
            chk("match time", f_cnt, 16'h0041);
            cyc(1); chk("pin action", pin_out[0], {15'h0000, i != 1});
        end
        wr(3'h0, 8'h00); wr(3'h3, 8'h00); ld(16'h0000); wr(3'h0, 8'h0b);
        for (i = 0; i < 2; i++) begin
            adc_enabled <= (i == 0);
            wr(3'h3, 8'h00);
            for (k = 0; k < 200 && f_rst !== 1'b1; k++) cyc(1);
            chk("adc start", adc_start, {15'h0000, i == 0});
            chk("third untouched", t_rst, 16'h0000);
            chk("special flag", flag, 16'h0001);
            cyc(1); chk("period reset", f_cnt, 16'h0000);
        end
        wr(3'h5, 8'h00); wr(3'h6, 8'h00); pwm_level <= 1'b1;
        for (i = 0; i < 5; i++) begin
            wr(3'h0, pctl[i]); cyc(3);
            chk("pwm pins", pin_out, pexp[i]);
            chk("pwm drive", pin_oe, 16'h000f);
        end
        final_report();
    end
endmodule : capture_compare_unit_tb_top
`default_nettype wire
